//--- rtl/fan_cfg_pkg.sv
/*
 * Shared constants, field layout, timing and carrier types for the
 * fan drive configuration block.
 * Assumes a 10 MHz aclk; temperatures arrive in quarter-degree units.
 */
package fan_cfg_pkg;

	// ------------------------------------------------------------
	// sizes and clock
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int NCH    = 3;
	localparam int AW     = 12;

	// ------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_SPAN_BASE = 8'h5F;
	localparam logic [7:0] IDX_RAMP      = 8'h62;
	localparam logic [7:0] IDX_CTRL      = 8'h63;
	localparam logic [7:0] IDX_STAT      = 8'h64;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SPAN_RST = 8'hC4;
	localparam logic [7:0] RAMP_RST = 8'h00;
	localparam logic [2:0] CTRL_RST = 3'h4;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RATE_LSB      = 0;
	localparam int OTEN_BIT      = 3;
	localparam int SPAN_LSB      = 4;
	localparam int RAMP_RATE_LSB = 0;
	localparam int RAMP_EN_BIT   = 3;
	localparam int LOCK_BIT      = 0;
	localparam int SLOW_BIT      = 1;
	localparam int PINFN_BIT     = 2;
	localparam int STAT_PIN_BIT  = 0;
	localparam int STAT_SEEN_BIT = 1;
	localparam int STAT_OE_BIT   = 2;
	localparam int STAT_DUTY_LSB = 8;
	localparam int STAT_OT_LSB   = 16;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int MONITOR_TIME_US   = 100_000;
	localparam int MONITOR_CYCLES    = CLK_HZ / 1_000_000 * MONITOR_TIME_US;
	localparam int RAMP_SLOT_TIME_US = 205_000;
	localparam int RAMP_SLOT_CYCLES  = CLK_HZ / 1_000_000 * RAMP_SLOT_TIME_US;
	localparam logic [1:0] SLOW_LAST = 2'h3;
	localparam int PWM_STEPS = 256;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic          awvalid;
		logic [AW-1:0] awaddr;
		logic          wvalid;
		logic [31:0]   wdata;
		logic [3:0]    wstrb;
		logic          bready;
		logic          arvalid;
		logic [AW-1:0] araddr;
		logic          rready;
	} axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic [9:0] temp;
		logic [9:0] limit;
		logic [9:0] tmin;
	} chan_in_t;

	// ------------------------------------------------------------
	// lookup functions
	// ------------------------------------------------------------
	// clock cycles per duty step; frequency held in centihertz
	function automatic logic [11:0] drive_step_cycles(input logic [2:0] c);
		int chz;
		chz = 1100;
		unique case (c)
			3'h0: chz = 1100;
			3'h1: chz = 1470;
			3'h2: chz = 2210;
			3'h3: chz = 2940;
			3'h4: chz = 3530;
			3'h5: chz = 4410;
			3'h6: chz = 5880;
			3'h7: chz = 8820;
		endcase
		return 12'(CLK_HZ / (chz * PWM_STEPS) * 100
			+ (CLK_HZ % (chz * PWM_STEPS)) * 100 / (chz * PWM_STEPS));
	endfunction

	// duty sixteenths per quarter degree: 1020 / span
	function automatic logic [9:0] span_slope(input logic [3:0] c);
		int sc;
		sc = 200;
		unique case (c)
			4'h0: sc = 200;
			4'h1: sc = 250;
			4'h2: sc = 333;
			4'h3: sc = 400;
			4'h4: sc = 500;
			4'h5: sc = 667;
			4'h6: sc = 800;
			4'h7: sc = 1000;
			4'h8: sc = 1333;
			4'h9: sc = 1600;
			4'hA: sc = 2000;
			4'hB: sc = 2667;
			4'hC: sc = 3200;
			4'hD: sc = 4000;
			4'hE: sc = 5333;
			4'hF: sc = 8000;
		endcase
		return 10'(102000 / sc);
	endfunction

	function automatic logic [7:0] slot_increase(input logic [2:0] c);
		logic [7:0] v;
		v = 8'h01;
		unique case (c)
			3'h0: v = 8'h01;
			3'h1: v = 8'h02;
			3'h2: v = 8'h03;
			3'h3: v = 8'h05;
			3'h4: v = 8'h08;
			3'h5: v = 8'h0C;
			3'h6: v = 8'h18;
			3'h7: v = 8'h30;
		endcase
		return v;
	endfunction

endpackage

//--- rtl/pwm_channel.sv
/*
 * One fan drive channel: 256 duty steps per period, each step a
 * programmable number of clock cycles long.
 * Assumes step_cycles and duty come from logic on the same clock.
 */
`timescale 1ns/1ps
module pwm_channel (
	input  wire logic        aclk,        // system clock
	input  wire logic        aresetn,     // sync reset, active low
	input  wire logic [11:0] step_cycles, // cycles per duty step
	input  wire logic [7:0]  duty,        // duty, FF means always on
	output logic             drive        // fan drive level
);
	logic [11:0] pre;
	logic [7:0]  phase;
	wire         step_end = (pre >= step_cycles - 12'h001);

	// ------------------------------------------------------------
	// period counter
	// ------------------------------------------------------------
	// >= so that a shorter step after a rate change wraps at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre   <= 12'h000;
			phase <= 8'h00;
			drive <= 1'b0;
		end else begin
			pre   <= step_end ? 12'h000 : pre + 12'h001;
			phase <= step_end ? phase + 8'h01 : phase;
			drive <= (duty == 8'hFF) || (phase < duty);
		end
	end

endmodule // pwm_channel

//--- rtl/fan_cfg_top.sv
/*
 * Fan drive configuration: per-channel rate and span registers,
 * overtemperature pin, duty ramp on the first output, AXI4-Lite slave.
 * Assumes temperatures, limits and minimum temperatures come from
 * same-clock logic; the overtemperature pin is open drain, pulled up.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
// Behaviour
// RULE1: three-bit code picks one of eight drive rates
// RULE2: drive rate resets to code 100
// RULE3: enabled channel over limit drives pin low
// RULE4: pin stays asserted until temperature at limit
// RULE5: each assertion lasts a full monitoring cycle
// RULE6: disabled output makes the pin an input
// RULE7: four-bit code picks the duty slope span
// RULE8: span resets to code 1100
// RULE9: lock bit freezes configuration registers against writes; the slow and pin bits of the control register stay writable
// RULE10: ramp register at index 62, reset zero
// RULE11: first output ramps toward new duty gradually
// RULE12: slow bit makes every ramp four times longer
// RULE13: ramping applies only while its enable is set
// RULE14: compare temperature with limit each monitoring cycle
`timescale 1ns/1ps
module fan_cfg_top
	import fan_cfg_pkg::*;
#(
	parameter int MON_CYCLES  = fan_cfg_pkg::MONITOR_CYCLES,
	parameter int RAMP_CYCLES = fan_cfg_pkg::RAMP_SLOT_CYCLES
) (
	input  wire logic                            aclk,     // 10 MHz clock
	input  wire logic                            aresetn,  // sync, low
	input  wire fan_cfg_pkg::axil_req_t          axi_req,  // bus request
	output fan_cfg_pkg::axil_rsp_t               axi_rsp,  // bus answer
	input  wire fan_cfg_pkg::chan_in_t [2:0]     chan,     // temperatures
	input  wire logic                            overtemp_pin_in,  // level
	output logic                                 overtemp_pin_out, // 0
	output logic                                 overtemp_pin_oe,  // drive
	output logic [2:0]                           fan_drive_output  // fans
);
	import fan_cfg_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:0]    span_reg [NCH];
	logic [7:0]    ramp_reg;
	logic [2:0]    ctrl_reg;
	logic          seen;
	logic          pin_s1;
	logic          pin_s2;
	logic [1:0]    oe_d;
	logic          aw_held;
	logic          w_held;
	logic [AW-1:0] aw_addr_q;
	logic [31:0]   w_data_q;
	logic [3:0]    w_strb_q;
	logic          bvalid;
	logic [1:0]    bresp;
	logic          rvalid;
	logic [31:0]   rdata;
	logic [1:0]    rresp;
	logic [23:0]   mon_cnt;
	logic [23:0]   slot_cnt;
	logic [1:0]    slow_cnt;
	logic [NCH-1:0] ot_q;
	logic [7:0]    target_q [NCH];
	logic [7:0]    cur_duty;
	logic [11:0]   step_sel [NCH];
	logic [9:0]    slope_sel [NCH];
	logic [7:0]    duty_calc [NCH];

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire       aw_take  = axi_req.awvalid && axi_rsp.awready;
	wire       w_take   = axi_req.wvalid && axi_rsp.wready;
	wire       ar_take  = axi_req.arvalid && axi_rsp.arready;
	wire       do_write = aw_held && w_held && !bvalid;
	wire [7:0] wr_idx   = aw_addr_q[9:2];
	wire       wr_inmap = (aw_addr_q[11:10] == 2'h0);
	wire       wr_lane0 = do_write && wr_inmap && w_strb_q[0];
	wire       locked   = ctrl_reg[LOCK_BIT];
	wire       slow     = ctrl_reg[SLOW_BIT];
	wire       pin_fn   = ctrl_reg[PINFN_BIT];
	wire       ramp_en  = ramp_reg[RAMP_EN_BIT];
	wire       wr_span_any = wr_idx >= IDX_SPAN_BASE
		&& wr_idx < IDX_RAMP;
	wire       wr_ok    = wr_idx == IDX_RAMP || wr_idx == IDX_CTRL
		|| wr_idx == IDX_STAT || wr_span_any;
	// RULE9 lock gate
	wire       cfg_wr   = wr_lane0 && !locked;
	wire       wr_ramp  = cfg_wr && wr_idx == IDX_RAMP;
	wire       wr_ctrl  = wr_lane0 && wr_idx == IDX_CTRL;
	wire       wr_stat  = wr_lane0 && wr_idx == IDX_STAT;
	wire [7:0] rd_idx   = axi_req.araddr[9:2];
	wire       rd_inmap = (axi_req.araddr[11:10] == 2'h0);
	wire [7:0] rd_span_n = rd_idx - IDX_SPAN_BASE;
	wire       rd_span  = rd_inmap && rd_idx >= IDX_SPAN_BASE
		&& rd_idx < IDX_RAMP;
	wire [31:0] stat_word = {13'h0000, ot_q, cur_duty, 5'h00,
		overtemp_pin_oe, seen, !pin_s2};
	wire [31:0] rd_word =
		rd_span ? {24'h000000, span_reg[rd_span_n[1:0]]} :
		(rd_idx == IDX_RAMP) ? {24'h000000, ramp_reg} :
		(rd_idx == IDX_CTRL) ? {29'h00000000, ctrl_reg} :
		(rd_idx == IDX_STAT) ? stat_word : 32'h00000000;
	wire       rd_ok    = rd_inmap && (rd_span || rd_idx == IDX_RAMP
		|| rd_idx == IDX_CTRL || rd_idx == IDX_STAT);

	assign axi_rsp.awready = !aw_held && !bvalid;
	assign axi_rsp.wready  = !w_held && !bvalid;
	assign axi_rsp.bvalid  = bvalid;
	assign axi_rsp.bresp   = bresp;
	assign axi_rsp.arready = !rvalid;
	assign axi_rsp.rvalid  = rvalid;
	assign axi_rsp.rdata   = rdata;
	assign axi_rsp.rresp   = rresp;

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held   <= 1'b1;
				aw_addr_q <= axi_req.awaddr;
			end
			if (w_take) begin
				w_held   <= 1'b1;
				w_data_q <= axi_req.wdata;
				w_strb_q <= axi_req.wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (wr_inmap && wr_ok) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && axi_req.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rdata  <= rd_word;
			rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && axi_req.rready) begin
			rvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// shared registers
	// ------------------------------------------------------------
	// lock cannot be cleared by software, only by reset
	// RULE10 ramp register reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ramp_reg <= RAMP_RST;
			ctrl_reg <= CTRL_RST;
		end else begin
			if (wr_ramp)
				ramp_reg <= w_data_q[7:0];
			if (wr_ctrl) begin
				ctrl_reg[LOCK_BIT]  <= locked | w_data_q[LOCK_BIT];
				ctrl_reg[SLOW_BIT]  <= w_data_q[SLOW_BIT];
				ctrl_reg[PINFN_BIT] <= w_data_q[PINFN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// pin sensing
	// ------------------------------------------------------------
	// RULE6 input when undriven
	wire pin_ext = pin_fn && !overtemp_pin_oe && !(|oe_d) && !pin_s2;
	wire seen_clr = wr_stat && w_data_q[STAT_SEEN_BIT];

	// new low beats clear; oe_d hides our own release in the sync
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			oe_d   <= 2'h0;
			seen   <= 1'b0;
		end else begin
			pin_s1 <= overtemp_pin_in;
			pin_s2 <= pin_s1;
			oe_d   <= {oe_d[0], overtemp_pin_oe};
			seen   <= pin_ext || (seen && !seen_clr);
		end
	end

	// ------------------------------------------------------------
	// monitoring and ramp timebase
	// ------------------------------------------------------------
	wire mon_tick  = (mon_cnt == 24'(MON_CYCLES - 1));
	wire slot_tick = (slot_cnt == 24'(RAMP_CYCLES - 1));
	// RULE12 four slots per step
	wire ramp_tick = slot_tick && (!slow || slow_cnt == SLOW_LAST);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mon_cnt  <= 24'h000000;
			slot_cnt <= 24'h000000;
			slow_cnt <= 2'h0;
		end else begin
			mon_cnt  <= mon_tick ? 24'h000000 : mon_cnt + 24'h000001;
			slot_cnt <= slot_tick ? 24'h000000 : slot_cnt + 24'h000001;
			if (slot_tick)
				slow_cnt <= slow_cnt + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// per-channel logic
	// ------------------------------------------------------------
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			wire        wr_this = cfg_wr && wr_idx == IDX_SPAN_BASE + 8'(c);
			wire        over    = chan[c].temp > chan[c].limit;
			wire [9:0]  delta   = (chan[c].temp > chan[c].tmin)
				? chan[c].temp - chan[c].tmin : 10'h000;
			wire [19:0] prod    = delta * slope_sel[c];

			// RULE1 rate lookup
			assign step_sel[c]  = drive_step_cycles(
				span_reg[c][RATE_LSB +: 3]);
			// RULE7 span lookup
			assign slope_sel[c] = span_slope(span_reg[c][SPAN_LSB +: 4]);
			assign duty_calc[c] = (|prod[19:12]) ? 8'hFF : prod[11:4];

			// RULE2 RULE8 span and rate reset
			always_ff @(posedge aclk) begin
				if (!aresetn)
					span_reg[c] <= SPAN_RST;
				else if (wr_this)
					span_reg[c] <= w_data_q[7:0];
			end

			// RULE14 RULE4 RULE5 decided once per cycle
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ot_q[c]     <= 1'b0;
					target_q[c] <= 8'h00;
				end else if (mon_tick) begin
					ot_q[c]     <= span_reg[c][OTEN_BIT] && over;
					target_q[c] <= duty_calc[c];
				end
			end

			pwm_channel u_pwm (
				.aclk        (aclk),
				.aresetn     (aresetn),
				.step_cycles (step_sel[c]),
				.duty        ((c == 0) ? cur_duty : target_q[c]),
				.drive       (fan_drive_output[c])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// overtemperature pin
	// ------------------------------------------------------------
	// RULE3 drive low when over
	always_ff @(posedge aclk) begin
		if (!aresetn)
			overtemp_pin_oe <= 1'b0;
		else
			overtemp_pin_oe <= pin_fn && (|ot_q);
	end
	assign overtemp_pin_out = 1'b0;

	// ------------------------------------------------------------
	// duty ramp on the first output
	// ------------------------------------------------------------
	wire [7:0] inc     = slot_increase(ramp_reg[RAMP_RATE_LSB +: 3]);
	wire [7:0] gap_up  = target_q[0] - cur_duty;
	wire [7:0] gap_dn  = cur_duty - target_q[0];
	wire [7:0] next_up = (gap_up > inc) ? cur_duty + inc : target_q[0];
	wire [7:0] next_dn = (gap_dn > inc) ? cur_duty - inc : target_q[0];

	// RULE13 RULE11 ramp only when enabled
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cur_duty <= 8'h00;
		else if (!ramp_en)
			cur_duty <= target_q[0];
		else if (ramp_tick)
			cur_duty <= (target_q[0] > cur_duty) ? next_up : next_dn;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence ot_set_s;
		mon_tick && span_reg[1][OTEN_BIT] && g_ch[1].over && pin_fn;
	endsequence
	sequence pin_low_s;
		ot_q[1] ##1 overtemp_pin_oe;
	endsequence

	rate_lookup_a: assert property ( // RULE1
		(span_reg[0][2:0] == 3'h4) |-> (step_sel[0] == 12'h452))
		else $error("drive step wrong for code 100");
	rate_reset_a: assert property ( // RULE2
		$rose(aresetn) |-> (span_reg[1][2:0] == 3'h4))
		else $error("drive rate not reset to 100");
	pin_assert_a: assert property ( // RULE3
		ot_set_s |=> pin_low_s)
		else $error("pin not driven after overtemperature");
	pin_hold_a: assert property ( // RULE4
		(ot_q[1] && !(mon_tick && !g_ch[1].over)) |=> ot_q[1])
		else $error("pin released while still over limit");
	min_cycle_a: assert property ( // RULE5
		!mon_tick |=> $stable(ot_q))
		else $error("overtemp state changed between cycles");
	pin_input_a: assert property ( // RULE6
		(pin_fn && !overtemp_pin_oe && !(|oe_d) && !pin_s2) |=> seen)
		else $error("external low not caught");
	span_slope_a: assert property ( // RULE7
		(span_reg[0][7:4] == 4'h0) |-> (slope_sel[0] == 10'h1FE))
		else $error("slope wrong for span code 0");
	span_reset_a: assert property ( // RULE8
		$rose(aresetn) |-> (span_reg[2][7:4] == 4'hC))
		else $error("span not reset to 1100");
	lock_freeze_a: assert property ( // RULE9
		(locked && do_write) |=> ($stable(span_reg[0]) && $stable(ramp_reg)))
		else $error("write landed while locked");
	ramp_reset_a: assert property ( // RULE10
		$rose(aresetn) |-> (ramp_reg == 8'h00))
		else $error("ramp register not reset");
	ramp_hold_a: assert property ( // RULE11
		($past(ramp_en) && !$past(ramp_tick)) |-> $stable(cur_duty))
		else $error("ramped duty moved off a ramp step");
	slow_step_a: assert property ( // RULE12
		(slow && ramp_tick) |-> (slow_cnt == 2'h3))
		else $error("slow ramp stepped early");
	ramp_bypass_a: assert property ( // RULE13
		!ramp_en |=> (cur_duty == $past(target_q[0])))
		else $error("duty ramped while ramp disabled");
	ot_clear_a: assert property ( // RULE14
		(mon_tick && !g_ch[1].over) |=> !ot_q[1])
		else $error("overtemp not cleared at limit");

endmodule // fan_cfg_top

//--- verification/fan_env_model.sv
/*
 * Far-side model: temperature sensing feeding the channel inputs and the
 * pulled-up overtemperature wire shared with other parties.
 * Assumes the bench steers it through its tasks, on the bench clock.
 */
`timescale 1ns/1ps
module fan_env_model
	import fan_cfg_pkg::*;
(
	input  wire logic                   aclk,             // clock
	output fan_cfg_pkg::chan_in_t [2:0] chan,             // sensor values
	input  wire logic                   overtemp_pin_out, // driven level
	input  wire logic                   overtemp_pin_oe,  // pull enable
	output logic                        overtemp_pin_in,  // wire level
	input  wire logic [2:0]             fan_drive_output  // fan drives
);
	import fan_cfg_pkg::*;

	logic ext_low; // another device pulling the wire low

	initial begin
		ext_low = 1'b0;
		for (int i = 0; i < 3; i++) begin
			chan[i] = {10'h064, 10'h0C8, 10'h064};
		end
	end

	// open drain with pull-up: high unless some party pulls it down
	assign overtemp_pin_in = ((overtemp_pin_oe && !overtemp_pin_out)
		|| ext_low) ? 1'b0 : 1'b1;

	task automatic set_temp(input int c, input logic [9:0] t);
		@(posedge aclk);
		chan[c].temp <= t;
	endtask

	task automatic pull(input logic v);
		@(posedge aclk);
		ext_low <= v;
	endtask
endmodule // fan_env_model

//--- verification/testbench.sv
/*
 * Self-checking bench for the fan drive configuration block.
 * Assumes short monitor and ramp intervals set through parameters.
 */
`timescale 1ns/1ps
module testbench;
	import fan_cfg_pkg::*;

	localparam int MON  = 50;
	localparam int RAMP = 20;
	localparam logic [11:0] A_SPAN = {2'h0, IDX_SPAN_BASE, 2'h0};
	localparam logic [11:0] A_RAMP = {2'h0, IDX_RAMP, 2'h0};
	localparam logic [11:0] A_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, IDX_STAT, 2'h0};

	logic                   aclk;
	logic                   aresetn;
	axil_req_t              req;
	axil_rsp_t              rsp;
	chan_in_t [2:0]         chan;
	logic                   pin_in;
	logic                   pin_out;
	logic                   oe;
	logic [2:0]             fan;
	logic [31:0]            rdat;
	logic [1:0]             resp;
	int                     fail_count;
	int                     compares;
	int                     cycles;
	int                     n;
	logic [7:0]             d0;

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	fan_cfg_top #(.MON_CYCLES(MON), .RAMP_CYCLES(RAMP)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.chan(chan), .overtemp_pin_in(pin_in),
		.overtemp_pin_out(pin_out), .overtemp_pin_oe(oe),
		.fan_drive_output(fan));

	fan_env_model i_env (
		.aclk(aclk), .chan(chan), .overtemp_pin_out(pin_out),
		.overtemp_pin_oe(oe), .overtemp_pin_in(pin_in),
		.fan_drive_output(fan));

	// ------------------------------------------------------------
	// bus tasks and checks
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge aclk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h0, v};
		req.wstrb <= 4'hF;
		req.bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				resp = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				rdat = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// cycles until the pin enable reaches v, bounded
	task automatic wait_oe(input logic v);
		n = 0;
		while (oe !== v && n < 8 * MON) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic complete_run;
		$display("mismatches %0d, comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard: the whole sequence needs under two thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		req = '0;
		fail_count = 0;
		compares = 0;
		cycles = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(A_SPAN + 12'(4 * i));
			chk(rdat, 32'h000000C4);
		end
		rd(A_RAMP);
		chk(rdat, 32'h00000000);
		chk({pin_out, fan}, 32'h0);
		for (int i = 0; i < 16; i++) begin
			wr(A_SPAN + 12'h004, {i[3:0], 1'b0, i[2:0]});
			rd(A_SPAN + 12'h004);
			chk(rdat, {24'h0, i[3:0], 1'b0, i[2:0]});
		end
		rd(12'h400);
		chk({resp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
		// overtemperature on the second channel, limit 0x0C8
		wr(A_SPAN + 12'h004, 8'hCC);
		i_env.set_temp(1, 10'h0D0);
		wait_oe(1'b1);
		chk(n <= MON + 3, 1'b1);
		repeat (2 * MON) @(posedge aclk);
		chk(oe, 1'b1);
		i_env.set_temp(1, 10'h0C8);
		wait_oe(1'b0);
		chk(n <= MON + 3, 1'b1);
		i_env.set_temp(1, 10'h0D0);
		wait_oe(1'b1);
		i_env.set_temp(1, 10'h0C8);
		wait_oe(1'b0);
		chk(n >= MON - 2, 1'b1);
		// output disabled: the pin is only watched
		wr(A_SPAN + 12'h004, 8'hC4);
		i_env.set_temp(1, 10'h0D0);
		repeat (2 * MON + 4) @(posedge aclk);
		chk(oe, 1'b0);
		rd(A_STAT);
		chk(rdat[2:0], 3'h0);
		i_env.pull(1'b1);
		repeat (4) @(posedge aclk);
		rd(A_STAT);
		chk(rdat[1:0], 2'h3);
		i_env.pull(1'b0);
		i_env.set_temp(1, 10'h0C8);
		wr(A_STAT, 8'h02);
		rd(A_STAT);
		chk(rdat[1:0], 2'h0);
		// first output: 40 quarter degrees over tmin, target 0x4D
		wr(A_RAMP, 8'h08);
		i_env.set_temp(0, 10'h08C);
		repeat (MON + 10 * RAMP) @(posedge aclk);
		rd(A_STAT);
		d0 = rdat[15:8];
		chk(d0 >= 8'h05 && d0 <= 8'h0E, 1'b1);
		wr(A_CTRL, 8'h06);
		repeat (20 * RAMP) @(posedge aclk);
		rd(A_STAT);
		chk(rdat[15:8] - d0 >= 3 && rdat[15:8] - d0 <= 9, 1'b1);
		wr(A_RAMP, 8'h00);
		repeat (MON + 4) @(posedge aclk);
		rd(A_STAT);
		chk(rdat[15:8], 8'h4D);
		i_env.set_temp(2, 10'h3FF);
		repeat (MON + 4) @(posedge aclk);
		chk(fan[2], 1'b1);
		// lock freezes span and ramp registers; writes still answer OKAY
		wr(A_CTRL, 8'h07);
		wr(A_SPAN, 8'h11);
		chk(resp, RESP_OKAY);
		rd(A_SPAN);
		chk(rdat, 32'h000000C4);
		wr(A_RAMP, 8'h0F);
		rd(A_RAMP);
		chk(rdat, 32'h00000000);
		complete_run();
	end
endmodule // testbench
